// ===== wfm_hyst.sv
/*
 * One hysteresis comparator: sets above (or below) a threshold,
 * clears past the recovery level. Evaluated only on tick.
 * Assumes threshold and delta are stable registers of the caller.
 */
`timescale 1ns/1ps
module wfm_hyst #(
    parameter bit LOW_SIDE = 1'b0
) (
    // Clock and reset
    input  wire logic                         core_clk,
    input  wire logic                         rst,
    // Evaluation strobe and operands
    input  wire logic                         tick,
    input  wire logic [wfm_pkg::MEAS_W-1:0]   meas,
    input  wire logic [wfm_pkg::MEAS_W-1:0]   thresh,
    input  wire logic [wfm_pkg::MEAS_W-1:0]   delta,
    // Flag
    output logic                              flag
);
    typedef struct packed {
        logic flag;
    } wfm_hyst_state_type;

    wfm_hyst_state_type state_reg;
    wfm_hyst_state_type state_next;
    logic [wfm_pkg::MEAS_W:0] recover;

    always_comb begin
        state_next = state_reg;
        // Widened so the sum cannot wrap and a negative difference sets the top bit
        if (LOW_SIDE) begin
            recover = {1'b0, thresh} + {1'b0, delta};
        end else begin
            recover = {1'b0, thresh} - {1'b0, delta};
        end
        if (tick) begin
            if (!LOW_SIDE) begin
                if (meas > thresh) begin
                    state_next.flag = 1'b1;
                end else if (!recover[wfm_pkg::MEAS_W] && {1'b0, meas} < recover) begin
                    state_next.flag = 1'b0;
                end
            end else begin
                if (meas < thresh) begin
                    state_next.flag = 1'b1;
                end else if ({1'b0, meas} > recover) begin
                    state_next.flag = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign flag = state_reg.flag;

    a_hyst_hold: assert property (@(posedge core_clk) disable iff (rst)
        !tick |=> flag == $past(flag))
        else $error("Hysteresis flag changed without a tick");
endmodule

// ===== wfm_pkg.sv
/*
 * Package for the warning flag monitor: flag bit positions, widths,
 * fixed temperature thresholds, mode codes and timing constants.
 * Assumes measurements arrive as unsigned fixed-point words from the
 * measurement path, all on core_clk.
 */
package wfm_pkg;

    localparam int MEAS_W = 16;
    localparam int FLAG_W = 32;
    localparam int FAN_N  = 3;

    // Clock and timing
    localparam longint CLK_HZ         = 20000000;
    localparam longint OVERLOAD_HOLD_MS = 1000;
    localparam longint OVERLOAD_HOLD_CYC = (CLK_HZ * OVERLOAD_HOLD_MS) / 1000;
    localparam int     HOLD_W         = 25;
    localparam int     TICK_W         = 16;
    localparam logic [TICK_W-1:0] TICK_DIV_DEFAULT = 16'h4e1f;
    localparam int     ZC_W           = 24;

    // Fixed temperature thresholds, 0.1 degC per lsb
    localparam logic [MEAS_W-1:0] TEMP_STAGE_LIMIT = 16'h0320;
    localparam logic [MEAS_W-1:0] TEMP_AIR_LIMIT   = 16'h0226;
    // Fan tach threshold, rpm
    localparam logic [MEAS_W-1:0] FAN_MIN_SPEED    = 16'h01f4;

    // Anti-island mode codes and power factor enable value
    localparam logic [1:0] ISL_KEEP_RUNNING = 2'h1;
    localparam logic [1:0] ISL_AUTO_RESUME  = 2'h3;
    localparam logic       PF_MODE_ON       = 1'h1;

    // Warning status word bit positions
    localparam int B_INV_I_A    = 0;
    localparam int B_GRID_V_AB  = 3;
    localparam int B_SYNC_UNLK  = 6;
    localparam int B_LOSS_PH    = 7;
    localparam int B_I_LIMIT    = 8;
    localparam int B_DC_P_LIM   = 9;
    localparam int B_AC_P_LIM   = 10;
    localparam int B_OVERLOAD   = 11;
    localparam int B_GRID_OOT   = 12;
    localparam int B_RES_DELAY  = 13;
    localparam int B_ISLAND     = 14;
    localparam int B_DC_I_HIGH  = 15;
    localparam int B_CONV_TEMP  = 16;
    localparam int B_INV_TEMP   = 17;
    localparam int B_AIR_TEMP   = 18;
    localparam int B_DC_V_LOW   = 19;
    localparam int B_DC_V_HIGH  = 20;
    localparam int B_FAN_1      = 21;
    localparam int B_HIGH_VOLTAGE_RIDE_THROUGH_OVR   = 24;
    localparam int B_SURGE      = 25;
    localparam int B_VOLT_VAR   = 26;
    localparam int B_VOLT_WATT  = 27;
    localparam int B_FREQ_WATT  = 28;
    localparam int B_AC_OPEN    = 29;
    localparam int B_DC_OPEN    = 30;

    localparam logic [FLAG_W-1:0] FLAGS_RESET = 32'h0000_0000;

endpackage

// ===== wfm_top.sv
/*
 * Warning flag monitor: builds the read-only warning status word from
 * measurements and status inputs, plus a warning output line.
 * Assumes all inputs are on core_clk except the line-sync lock
 * and zero-crossing pins, which are synchronised here.
 */
// What this block does
// - Warning flags never block operation; they self-clear unless stated otherwise.
// - All flags form one status word; optional warning output while any set.
// - Per-phase inverter current flag with threshold and recover delta hysteresis.
// - Per line-to-line voltage flag with threshold and recover delta hysteresis.
// - Line-sync unlocked flag follows loss of lock, clears on relock.
// - Loss of phase when any phase misses a zero crossing in period.
// - Current limit flag: clamping in grid-tie, virtual impedance in grid-forming.
// - DC power limit: curtailment in grid-tie, low available power in grid-forming.
// - AC power limit: VA exceeded in grid-tie, or PF mode reactive overflow.
// - Hardware current-limit event holds overload flag about one second.
// - Grid out of tolerance flag while offline for that reason.
// - Resume delay flag throughout the reconnection delay.
// - Island warning when island detected and mode is 1 or 3.
// - DC input current flag with threshold and recover delta hysteresis.
// - Fixed temperature flags: stages near 80 C, enclosure air near 55 C.
// - Low DC input voltage flag, clears above threshold plus delta.
// - High DC input voltage flag, clears below threshold minus delta.
// - Fan flags set on low speed, clear only after fan runs well.
// - Ride-through override flag on region clamp or default curve use.
// - Surge suppressor flag latches; only power-on reset clears it.
// - Separate flags for active volt-var, volt-watt, frequency-watt functions.
// - AC and DC contactor-open flags follow their contactors.
`timescale 1ns/1ps
module wfm_top (
    // Clock and reset
    input  wire logic                           core_clk,
    input  wire logic                           rst,
    // Monitoring tick divider
    input  wire logic [wfm_pkg::TICK_W-1:0]     tick_div,
    // Phase currents and line voltages
    input  wire logic [3*wfm_pkg::MEAS_W-1:0]   inv_current,
    input  wire logic [wfm_pkg::MEAS_W-1:0]     inv_i_thresh,
    input  wire logic [wfm_pkg::MEAS_W-1:0]     inv_i_delta,
    input  wire logic [3*wfm_pkg::MEAS_W-1:0]   line_voltage,
    input  wire logic [wfm_pkg::MEAS_W-1:0]     grid_v_thresh,
    input  wire logic [wfm_pkg::MEAS_W-1:0]     grid_v_delta,
    // DC input
    input  wire logic [wfm_pkg::MEAS_W-1:0]     dc_current,
    input  wire logic [wfm_pkg::MEAS_W-1:0]     dc_i_thresh,
    input  wire logic [wfm_pkg::MEAS_W-1:0]     dc_i_delta,
    input  wire logic [wfm_pkg::MEAS_W-1:0]     dc_voltage,
    input  wire logic [wfm_pkg::MEAS_W-1:0]     dc_uv_thresh,
    input  wire logic [wfm_pkg::MEAS_W-1:0]     dc_uv_delta,
    input  wire logic [wfm_pkg::MEAS_W-1:0]     dc_ov_thresh,
    input  wire logic [wfm_pkg::MEAS_W-1:0]     dc_ov_delta,
    // Temperatures, 0.1 degC per lsb
    input  wire logic [wfm_pkg::MEAS_W-1:0]     conv_temp,
    input  wire logic [wfm_pkg::MEAS_W-1:0]     inv_temp,
    input  wire logic [wfm_pkg::MEAS_W-1:0]     air_temp,
    // Fans
    input  wire logic [3*wfm_pkg::MEAS_W-1:0]   fan_speed,
    input  wire logic [wfm_pkg::FAN_N-1:0]      fan_on,
    // Line sync and zero crossings, asynchronous pins
    input  wire logic                           sync_locked_pin,
    input  wire logic [2:0]                     zero_cross_pin,
    input  wire logic [wfm_pkg::ZC_W-1:0]       zc_period_cyc,
    // Operating status from the control path
    input  wire logic                           grid_form_mode,
    input  wire logic                           i_clamp_active,
    input  wire logic                           virt_imp_active,
    input  wire logic                           dc_curtail_active,
    input  wire logic                           dc_power_below_rated,
    input  wire logic                           va_exceeded,
    input  wire logic                           pf_mode_enable,
    input  wire logic                           q_cmd_over_max,
    input  wire logic                           hw_limit_event,
    input  wire logic                           offline_grid_oot,
    input  wire logic                           resume_delay_active,
    input  wire logic                           island_detected,
    input  wire logic [1:0]                     island_mode,
    input  wire logic                           ride_through_clamped,
    input  wire logic                           ride_through_default,
    input  wire logic                           surge_suppressor_damaged,
    input  wire logic                           volt_var_active,
    input  wire logic                           volt_watt_active,
    input  wire logic                           freq_watt_active,
    input  wire logic                           ac_contactor_open,
    input  wire logic                           dc_contactor_open,
    // Status word access
    input  wire logic                           status_wr,
    input  wire logic [wfm_pkg::FLAG_W-1:0]     status_wdata,
    input  wire logic                           warn_out_enable,
    output logic      [wfm_pkg::FLAG_W-1:0]     warning_status,
    output logic                                warning_out
);
    typedef struct packed {
        logic [wfm_pkg::TICK_W-1:0]     tick_cnt;
        logic                           tick;
        logic                           lock_s1;
        logic                           lock_s2;
        logic [2:0]                     zc_s1;
        logic [2:0]                     zc_s2;
        logic [2:0]                     zc_prev;
        logic [3*wfm_pkg::ZC_W-1:0]     zc_age;
        logic [wfm_pkg::HOLD_W-1:0]     hold_cnt;
        logic [wfm_pkg::FAN_N-1:0]      fan_flag;
        logic                           surge_flag;
        logic [wfm_pkg::FLAG_W-1:0]     status;
        logic                           warn;
    } wfm_top_state_type;

    wfm_top_state_type state_reg;
    wfm_top_state_type state_next;

    logic [2:0] inv_i_flag;
    logic [2:0] grid_v_flag;
    logic       dc_i_flag;
    logic       dc_uv_flag;
    logic       dc_ov_flag;

    // Hysteresis comparators, one instance per flag; DC voltage feeds two
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_phase
            wfm_hyst #(.LOW_SIDE(1'b0)) u_inv_i (
                .core_clk (core_clk),
                .rst      (rst),
                .tick     (state_reg.tick),
                .meas     (inv_current[g*wfm_pkg::MEAS_W +: wfm_pkg::MEAS_W]),
                .thresh   (inv_i_thresh),
                .delta    (inv_i_delta),
                .flag     (inv_i_flag[g])
            );
            wfm_hyst #(.LOW_SIDE(1'b0)) u_grid_v (
                .core_clk (core_clk),
                .rst      (rst),
                .tick     (state_reg.tick),
                .meas     (line_voltage[g*wfm_pkg::MEAS_W +: wfm_pkg::MEAS_W]),
                .thresh   (grid_v_thresh),
                .delta    (grid_v_delta),
                .flag     (grid_v_flag[g])
            );
        end
    endgenerate

    wfm_hyst #(.LOW_SIDE(1'b0)) u_dc_i (
        .core_clk (core_clk),
        .rst      (rst),
        .tick     (state_reg.tick),
        .meas     (dc_current),
        .thresh   (dc_i_thresh),
        .delta    (dc_i_delta),
        .flag     (dc_i_flag)
    );

    wfm_hyst #(.LOW_SIDE(1'b1)) u_dc_uv (
        .core_clk (core_clk),
        .rst      (rst),
        .tick     (state_reg.tick),
        .meas     (dc_voltage),
        .thresh   (dc_uv_thresh),
        .delta    (dc_uv_delta),
        .flag     (dc_uv_flag)
    );

    wfm_hyst #(.LOW_SIDE(1'b0)) u_dc_ov (
        .core_clk (core_clk),
        .rst      (rst),
        .tick     (state_reg.tick),
        .meas     (dc_voltage),
        .thresh   (dc_ov_thresh),
        .delta    (dc_ov_delta),
        .flag     (dc_ov_flag)
    );

    logic [wfm_pkg::ZC_W-1:0] age_i;
    logic                     loss_any;
    logic [wfm_pkg::FLAG_W-1:0] w;

    always_comb begin
        state_next = state_reg;
        age_i      = '0;
        loss_any   = 1'b0;
        w          = wfm_pkg::FLAGS_RESET;

        // Tick divider; a divider of zero ticks every cycle
        state_next.tick = 1'b0;
        if (state_reg.tick_cnt >= tick_div) begin
            state_next.tick_cnt = '0;
            state_next.tick     = 1'b1;
        end else begin
            state_next.tick_cnt = state_reg.tick_cnt + 1'b1;
        end

        state_next.lock_s1 = sync_locked_pin;
        state_next.lock_s2 = state_reg.lock_s1;
        state_next.zc_s1   = zero_cross_pin;
        state_next.zc_s2   = state_reg.zc_s1;
        state_next.zc_prev = state_reg.zc_s2;

        // Age since the last rising crossing, saturating
        for (int p = 0; p < 3; p++) begin
            age_i = state_reg.zc_age[p*wfm_pkg::ZC_W +: wfm_pkg::ZC_W];
            if (state_reg.zc_s2[p] && !state_reg.zc_prev[p]) begin
                age_i = '0;
            end else if (age_i != '1) begin
                age_i = age_i + 1'b1;
            end
            state_next.zc_age[p*wfm_pkg::ZC_W +: wfm_pkg::ZC_W] = age_i;
            if (age_i > zc_period_cyc) begin
                loss_any = 1'b1;
            end
        end

        // Overload hold restarts on every event
        if (hw_limit_event) begin
            state_next.hold_cnt = wfm_pkg::HOLD_W'(wfm_pkg::OVERLOAD_HOLD_CYC);
        end else if (state_reg.hold_cnt != '0) begin
            state_next.hold_cnt = state_reg.hold_cnt - 1'b1;
        end

        // Fan flags stay set while off; only a good spin clears them
        for (int f = 0; f < wfm_pkg::FAN_N; f++) begin
            if (state_reg.tick && fan_on[f]) begin
                if (fan_speed[f*wfm_pkg::MEAS_W +: wfm_pkg::MEAS_W] < wfm_pkg::FAN_MIN_SPEED) begin
                    state_next.fan_flag[f] = 1'b1;
                end else begin
                    state_next.fan_flag[f] = 1'b0;
                end
            end
        end

        // Sticky until reset; status writes never reach it
        if (surge_suppressor_damaged) begin
            state_next.surge_flag = 1'b1;
        end

        w[wfm_pkg::B_INV_I_A +: 3]   = inv_i_flag;
        w[wfm_pkg::B_GRID_V_AB +: 3] = grid_v_flag;
        w[wfm_pkg::B_SYNC_UNLK]      = !state_reg.lock_s2;
        w[wfm_pkg::B_LOSS_PH]        = loss_any;
        w[wfm_pkg::B_I_LIMIT]        = grid_form_mode ? virt_imp_active : i_clamp_active;
        w[wfm_pkg::B_DC_P_LIM]       = grid_form_mode ? dc_power_below_rated : dc_curtail_active;
        w[wfm_pkg::B_AC_P_LIM]       = (!grid_form_mode && va_exceeded)
                                     || (pf_mode_enable == wfm_pkg::PF_MODE_ON && q_cmd_over_max);
        w[wfm_pkg::B_OVERLOAD]       = state_reg.hold_cnt != '0;
        w[wfm_pkg::B_GRID_OOT]       = offline_grid_oot;
        w[wfm_pkg::B_RES_DELAY]      = resume_delay_active;
        w[wfm_pkg::B_ISLAND]         = island_detected && (island_mode == wfm_pkg::ISL_KEEP_RUNNING
                                     || island_mode == wfm_pkg::ISL_AUTO_RESUME);
        w[wfm_pkg::B_DC_I_HIGH]      = dc_i_flag;
        w[wfm_pkg::B_CONV_TEMP]      = conv_temp > wfm_pkg::TEMP_STAGE_LIMIT;
        w[wfm_pkg::B_INV_TEMP]       = inv_temp > wfm_pkg::TEMP_STAGE_LIMIT;
        w[wfm_pkg::B_AIR_TEMP]       = air_temp > wfm_pkg::TEMP_AIR_LIMIT;
        w[wfm_pkg::B_DC_V_LOW]       = dc_uv_flag;
        w[wfm_pkg::B_DC_V_HIGH]      = dc_ov_flag;
        w[wfm_pkg::B_FAN_1 +: 3]     = state_reg.fan_flag;
        w[wfm_pkg::B_HIGH_VOLTAGE_RIDE_THROUGH_OVR]       = ride_through_clamped || ride_through_default;
        w[wfm_pkg::B_SURGE]          = state_reg.surge_flag;
        w[wfm_pkg::B_VOLT_VAR]       = volt_var_active;
        w[wfm_pkg::B_VOLT_WATT]      = volt_watt_active;
        w[wfm_pkg::B_FREQ_WATT]      = freq_watt_active;
        w[wfm_pkg::B_AC_OPEN]        = ac_contactor_open;
        w[wfm_pkg::B_DC_OPEN]        = dc_contactor_open;

        // Status is rebuilt from conditions only; status_wr is ignored
        state_next.status = w;
        state_next.warn   = warn_out_enable && (w != '0);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= '0;
            state_reg.lock_s1 <= 1'b1;
            state_reg.lock_s2 <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign warning_status = state_reg.status;
    assign warning_out    = state_reg.warn;

    a_overload_hold: assert property (@(posedge core_clk) disable iff (rst)
        hw_limit_event |=> ##1 warning_status[wfm_pkg::B_OVERLOAD])
        else $error("Overload flag not raised after event");
    a_surge_latch: assert property (@(posedge core_clk) disable iff (rst)
        warning_status[wfm_pkg::B_SURGE] |=> warning_status[wfm_pkg::B_SURGE])
        else $error("Surge flag cleared without reset");
    a_write_ignored: assert property (@(posedge core_clk) disable iff (rst)
        status_wr && $stable(w) |=> warning_status == $past(w))
        else $error("Write disturbed status word");
    a_island_mode: assert property (@(posedge core_clk) disable iff (rst)
        island_detected && island_mode == 2'h2 |=> !warning_status[wfm_pkg::B_ISLAND])
        else $error("Island warning in fault mode");
    a_contactor_open: assert property (@(posedge core_clk) disable iff (rst)
        ac_contactor_open |=> warning_status[wfm_pkg::B_AC_OPEN])
        else $error("AC contactor flag missing");
    a_sync_unlock: assert property (@(posedge core_clk) disable iff (rst)
        !sync_locked_pin [*4] |-> warning_status[wfm_pkg::B_SYNC_UNLK])
        else $error("Unlock flag missing");
    a_warn_out: assert property (@(posedge core_clk) disable iff (rst)
        warning_out |-> warning_status != '0)
        else $error("Warning output without a flag");
    a_i_limit_mode: assert property (@(posedge core_clk) disable iff (rst)
        !grid_form_mode && i_clamp_active |=> warning_status[wfm_pkg::B_I_LIMIT])
        else $error("Current limit flag missing");
    a_dc_p_form: assert property (@(posedge core_clk) disable iff (rst)
        grid_form_mode && dc_power_below_rated |=> warning_status[wfm_pkg::B_DC_P_LIM])
        else $error("DC power limit flag missing in grid-forming");
    a_loss_phase: assert property (@(posedge core_clk) disable iff (rst)
        loss_any |=> warning_status[wfm_pkg::B_LOSS_PH])
        else $error("Loss of phase flag missing");
    a_overload_keep: assert property (@(posedge core_clk) disable iff (rst)
        state_reg.hold_cnt != '0 |=> warning_status[wfm_pkg::B_OVERLOAD])
        else $error("Overload flag dropped during hold");
    a_temp_fixed: assert property (@(posedge core_clk) disable iff (rst)
        conv_temp > wfm_pkg::TEMP_STAGE_LIMIT |=> warning_status[wfm_pkg::B_CONV_TEMP])
        else $error("Converter temperature flag missing");
    a_fan_hold: assert property (@(posedge core_clk) disable iff (rst)
        !fan_on[0] |=> state_reg.fan_flag[0] == $past(state_reg.fan_flag[0]))
        else $error("Fan flag changed while fan off");
    a_surge_set: assert property (@(posedge core_clk) disable iff (rst)
        surge_suppressor_damaged |=> state_reg.surge_flag)
        else $error("Surge latch not set");
    a_dc_open: assert property (@(posedge core_clk) disable iff (rst)
        dc_contactor_open |=> warning_status[wfm_pkg::B_DC_OPEN])
        else $error("DC contactor flag missing");
    a_top_bit_zero: assert property (@(posedge core_clk) disable iff (rst)
        warning_status[wfm_pkg::FLAG_W-1] == 1'b0)
        else $error("Unused status bit set");

    // Main scenarios worth seeing in a run
    c_overload: cover property (@(posedge core_clk) hw_limit_event ##2 warning_out);
    c_fan_flag: cover property (@(posedge core_clk) warning_status[wfm_pkg::B_FAN_1 +: 3] != 3'h0);
    c_island: cover property (@(posedge core_clk) warning_status[wfm_pkg::B_ISLAND]);
    c_surge: cover property (@(posedge core_clk) warning_status[wfm_pkg::B_SURGE]);
    c_loss_phase: cover property (@(posedge core_clk) warning_status[wfm_pkg::B_LOSS_PH]);
endmodule

// ===== wfm_top_test.sv
/*
 * Self-checking bench for the warning flag monitor top level.
 * Assumes the package and design files are compiled ahead of it.
 */
`timescale 1ns/1ps
module wfm_top_test;
    typedef struct {logic [19:0] st; logic [31:0] exp;} wfm_row_type;
    logic        core_clk, rst, wr, wen, hw, surge, lock;
    logic [19:0] st;
    logic [47:0] ic, lv, fs;
    logic [15:0] thr, dlt, uthr, othr, dci, dcv, ct, it, at, td;
    logic [2:0]  zc, zrun, fon;
    logic [31:0] wd, ws;
    logic        wo;
    int          err_total, checked;
    // Status vector: 0 grid form, 1..17 single status inputs, 19:18 island mode
    wfm_row_type rows [20] = '{'{20'h10000, 32'h2000_0000}, '{20'h20000, 32'h4000_0000},
        '{20'h00002, 32'h100}, '{20'h00005, 32'h100}, '{20'h00008, 32'h200}, '{20'h00011, 32'h200},
        '{20'h00020, 32'h400}, '{20'h000c0, 32'h400}, '{20'h00080, 32'h0}, '{20'h00100, 32'h1000},
        '{20'h00200, 32'h2000}, '{20'h00400, 32'h0}, '{20'h40400, 32'h4000}, '{20'h80400, 32'h0},
        '{20'hc0400, 32'h4000}, '{20'h00800, 32'h100_0000}, '{20'h01000, 32'h100_0000},
        '{20'h02000, 32'h400_0000}, '{20'h04000, 32'h800_0000}, '{20'h08000, 32'h1000_0000}};

    wfm_top wfm_top_inst (
        .core_clk(core_clk), .rst(rst), .tick_div(td),
        .inv_current(ic), .inv_i_thresh(thr), .inv_i_delta(dlt),
        .line_voltage(lv), .grid_v_thresh(thr), .grid_v_delta(dlt),
        .dc_current(dci), .dc_i_thresh(thr), .dc_i_delta(dlt), .dc_voltage(dcv),
        .dc_uv_thresh(uthr), .dc_uv_delta(dlt), .dc_ov_thresh(othr), .dc_ov_delta(dlt),
        .conv_temp(ct), .inv_temp(it), .air_temp(at), .fan_speed(fs), .fan_on(fon),
        .sync_locked_pin(lock), .zero_cross_pin(zc), .zc_period_cyc(24'h000400),
        .grid_form_mode(st[0]), .i_clamp_active(st[1]), .virt_imp_active(st[2]),
        .dc_curtail_active(st[3]), .dc_power_below_rated(st[4]), .va_exceeded(st[5]),
        .pf_mode_enable(st[6]), .q_cmd_over_max(st[7]), .hw_limit_event(hw),
        .offline_grid_oot(st[8]), .resume_delay_active(st[9]), .island_detected(st[10]),
        .island_mode(st[19:18]), .ride_through_clamped(st[11]), .ride_through_default(st[12]),
        .surge_suppressor_damaged(surge), .volt_var_active(st[13]), .volt_watt_active(st[14]),
        .freq_watt_active(st[15]), .ac_contactor_open(st[16]), .dc_contactor_open(st[17]),
        .status_wr(wr), .status_wdata(wd), .warn_out_enable(wen),
        .warning_status(ws), .warning_out(wo));

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: status %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: warning line %b expected %b", $time, got, exp);
        end
    endtask

    // Inputs change at the falling edge, so results are settled here
    task automatic step(input int n, input logic [31:0] exp);
        repeat (n) @(negedge core_clk);
        chk_word(ws, exp);
        chk_bit(wo, wen & (|exp));
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Rising crossing every 200 cycles per running phase
    initial begin
        zc = 3'h0;
        forever begin
            repeat (100) @(negedge core_clk);
            zc = zc ^ zrun;
        end
    end

    // Whole run is under 6000 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        end_sim;
    end

    initial begin
        rst = 1'b1; wr = 1'b0; wen = 1'b1; hw = 1'b0; surge = 1'b0; lock = 1'b1; st = 20'h0;
        thr = 16'h03e8; dlt = 16'h0064; uthr = 16'h0190; othr = 16'h0320;
        ic = 48'h0; lv = 48'h0; fs = {3{16'h03e8}}; fon = 3'h7; zrun = 3'h7; wd = 32'hffff_ffff; td = 16'h0000;
        dci = 16'h0; dcv = 16'h0258; ct = 16'h0; it = 16'h0; at = 16'h0;
        repeat (12) @(negedge core_clk);
        rst = 1'b0;
        step(1, 32'h0);
        foreach (rows[i]) begin
            st = rows[i].st;
            step(4, rows[i].exp);
        end
        st = 20'h0;
        $display("test status table done");
        ic[31:16] = 16'h03e8; step(4, 32'h0);
        ic[31:16] = 16'h03e9; step(4, 32'h2);
        ic[31:16] = 16'h0384; step(4, 32'h2);
        ic[31:16] = 16'h0383; step(4, 32'h0);
        lv[47:32] = 16'h03e9; step(4, 32'h20);
        lv[47:32] = 16'h0; dci = 16'h03e9; step(4, 32'h8000);
        dci = 16'h0; dcv = 16'h018f; step(4, 32'h8_0000);
        dcv = 16'h01f4; step(4, 32'h8_0000);
        dcv = 16'h01f5; step(4, 32'h0);
        dcv = 16'h0321; step(4, 32'h10_0000);
        dcv = 16'h02bc; step(4, 32'h10_0000);
        dcv = 16'h02bb; step(4, 32'h0);
        td = 16'h0007; ic[15:0] = 16'h03e9; step(12, 32'h1);
        ic[15:0] = 16'h0; step(12, 32'h0);
        td = 16'h0000;
        $display("test thresholds done");
        ct = wfm_pkg::TEMP_STAGE_LIMIT; it = ct; at = wfm_pkg::TEMP_AIR_LIMIT; step(4, 32'h0);
        ct++; it++; at++; step(4, 32'h7_0000);
        ct = 16'h0; it = 16'h0; at = 16'h0; fs[31:16] = 16'h0064; step(4, 32'h40_0000);
        fon = 3'h5; fs[31:16] = 16'h03e8; step(4, 32'h40_0000);
        fon = 3'h7; step(4, 32'h0);
        lock = 1'b0; step(6, 32'h40);
        lock = 1'b1; step(6, 32'h0);
        zrun = 3'h3; step(1200, 32'h80);
        zrun = 3'h7; step(1200, 32'h0);
        $display("test temps fans sync phase done");
        hw = 1'b1; @(negedge core_clk);
        hw = 1'b0; step(1, 32'h800);
        step(1000, 32'h800);
        surge = 1'b1; @(negedge core_clk);
        surge = 1'b0; wr = 1'b1; step(4, 32'h200_0800);
        wr = 1'b0; step(500, 32'h200_0800);
        wen = 1'b0; step(1, 32'h200_0800);
        wen = 1'b1; rst = 1'b1; step(2, 32'h0);
        rst = 1'b0; step(4, 32'h0);
        $display("test overload surge reset done");
        end_sim;
    end
endmodule
